/* common/gpib_pkg.sv */
package gpib_pkg;
   localparam int  GPIB_DW        = 8;
   localparam int  GPIB_FIFO_DEPTH = 32;
   // interface message codes (received with attention low)
   localparam logic [7:0] CMD_DCL  = 8'h14;
   localparam logic [7:0] CMD_SDC  = 8'h04;
   localparam logic [7:0] CMD_GET  = 8'h08;
   localparam logic [7:0] CMD_GTL  = 8'h01;
   localparam logic [7:0] CMD_LLO  = 8'h11;
   localparam logic [7:0] CMD_PPC  = 8'h05;
   localparam logic [7:0] CMD_PPU  = 8'h15;
   localparam logic [7:0] CMD_SPE  = 8'h18;
   localparam logic [7:0] CMD_SPD  = 8'h19;
   localparam logic [7:0] CMD_UNL  = 8'h3f;
   localparam logic [7:0] CMD_UNT  = 8'h5f;
   localparam logic [2:0] GRP_LAD  = 3'h1;
   localparam logic [2:0] GRP_TAD  = 3'h2;
   localparam logic [3:0] GRP_PPE  = 4'h6;
   localparam logic [3:0] GRP_PPD  = 4'h7;
   localparam logic [4:0] RST_ADDR = 5'h00;
   // settle time before asserting data valid
   localparam int  T_SETTLE_NS    = 100;
   localparam int  CLK_PERIOD_NS  = 20;
   localparam int  SETTLE_CYC     = (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] SETTLE_CNT = SETTLE_CYC[2:0];
   typedef enum logic [3:0]
   {
      GPIB_SH_IDLE = 4'b0001,
      GPIB_SH_WRDY = 4'b0010,
      GPIB_SH_SETL = 4'b0100,
      GPIB_SH_WACC = 4'b1000
   } gpib_sh_e;
   typedef enum logic [2:0]
   {
      GPIB_AH_RDY  = 3'b001,
      GPIB_AH_ACC  = 3'b010,
      GPIB_AH_WREL = 3'b100
   } gpib_ah_e;
endpackage

/* rtl/gpib_dev.sv */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - eight data lines carry one byte, line zero least significant.
// - five control and three handshake lines, all asserted low.
// - interface clear low returns all interface functions except remote/local, lockout and service request to idle.
// - attention low means command bytes, high means data bytes.
// - device pulls service request low to ask for service.
// - remote state only while remote enable held low.
// - end line with attention high marks last byte both ways.
// - end line with attention low starts parallel poll response.
// - data valid asserted only while byte stable on lines.
// - hold not ready for data low until able to accept.
// - hold not data accepted low until byte taken.
// - full source handshake for sending.
// - full acceptor handshake for receiving.
// - listener, unaddressed by own talk address.
// - talker with serial poll, unaddressed by own listen address.
// - full service request function.
// - full parallel poll response function.
// - remote/local function with local lockout.
// - device clear resets device-side message handling.
// - group execute trigger produces trigger pulse when listening.
module gpib_dev
   import gpib_pkg::*;
(
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   // bus data lines, active low
   input  wire logic [7:0]   dio_n_i,
   output logic      [7:0]   dio_n_o,
   output logic              dio_oe_o,
   // bus control lines, active low
   input  wire logic         atn_n_i,
   input  wire logic         ifc_n_i,
   input  wire logic         ren_n_i,
   input  wire logic         eoi_n_i,
   output logic              eoi_n_o,
   output logic              eoi_oe_o,
   output logic              srq_n_o,
   output logic              srq_oe_o,
   // bus handshake lines, active low
   input  wire logic         dav_n_i,
   output logic              dav_n_o,
   output logic              dav_oe_o,
   input  wire logic         nrfd_n_i,
   output logic              nrfd_n_o,
   output logic              nrfd_oe_o,
   input  wire logic         ndac_n_i,
   output logic              ndac_n_o,
   output logic              ndac_oe_o,
   // device configuration
   input  wire logic [4:0]   my_addr_i,
   input  wire logic         lpe_i,
   // received data stream
   output logic              rx_valid_o,
   input  wire logic         rx_ready_i,
   output logic [7:0]        rx_data_o,
   output logic              rx_end_o,
   // transmit data stream
   input  wire logic         tx_valid_i,
   output logic              tx_ready_o,
   input  wire logic [7:0]   tx_data_i,
   input  wire logic         tx_end_i,
   // service and status
   input  wire logic         rsv_i,
   input  wire logic [6:0]   status_i,
   input  wire logic         ist_i,
   // status outputs
   output logic              remote_o,
   output logic              lockout_o,
   output logic              listen_o,
   output logic              talk_o,
   output logic              trigger_o,
   output logic              dev_clear_o
);
   import gpib_pkg::*;

   // two-stage synchronisers
   logic [14:0] s1_ff;
   logic [14:0] s2_ff;
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         s1_ff <= 15'h7fff;
         s2_ff <= 15'h7fff;
      end
      else
      begin
         s1_ff <= {dio_n_i, atn_n_i, ifc_n_i, ren_n_i, eoi_n_i, dav_n_i, nrfd_n_i, ndac_n_i};
         s2_ff <= s1_ff;
      end
   end
   logic [7:0] bus_d;
   logic atn, ifc, ren, eoi, dav, nrfd, ndac;
   assign bus_d = ~s2_ff[14:7];
   assign atn   = ~s2_ff[6];
   assign ifc   = ~s2_ff[5];
   assign ren   = ~s2_ff[4];
   assign eoi   = ~s2_ff[3];
   assign dav   = ~s2_ff[2];
   assign nrfd  = ~s2_ff[1];
   assign ndac  = ~s2_ff[0];

   function automatic logic is_addr(input logic [7:0] b, input logic [2:0] g);
      is_addr = (b[6:5] == g[1:0]) && (b[4:0] == my_addr_i);
   endfunction

   // receive fifo
   logic       fifo_in_valid;
   logic       fifo_in_ready;
   logic [8:0] fifo_out;
   logic       clr_ff;

   // acceptor handshake
   gpib_ah_e   ah_ff;
   logic [7:0] rx_byte_ff;
   logic       rx_eoi_ff;
   logic       take;
   logic       listen_ff;
   logic       talk_ff;
   logic       spe_ff;
   logic       lockout_ff;
   logic       remote_ff;
   logic       ppe_ff;
   logic       ppsense_ff;
   logic [2:0] ppline_ff;
   logic       trig_ff;
   logic       acc_active;

   assign acc_active = atn || listen_ff;
   assign take       = (ah_ff == GPIB_AH_ACC);

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i || ifc)
         ah_ff <= GPIB_AH_RDY;
      else
      begin
         unique case (ah_ff)
            GPIB_AH_RDY:
               if (dav && acc_active && (atn || fifo_in_ready))
                  ah_ff <= GPIB_AH_ACC;
            GPIB_AH_ACC:
               ah_ff <= GPIB_AH_WREL;
            GPIB_AH_WREL:
               if (!dav)
                  ah_ff <= GPIB_AH_RDY;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         rx_byte_ff <= 8'h00;
         rx_eoi_ff  <= 1'b0;
      end
      else if (ah_ff == GPIB_AH_RDY && dav)
      begin
         rx_byte_ff <= bus_d;
         rx_eoi_ff  <= eoi && !atn;
      end
   end

   // not ready while busy or fifo full; not accepted until byte taken
   logic nrfd_hold;
   logic ndac_hold;
   assign nrfd_hold = acc_active && (ah_ff != GPIB_AH_RDY || (!atn && !fifo_in_ready));
   assign ndac_hold = acc_active && (ah_ff != GPIB_AH_WREL);

   // command decode
   logic cmd;
   logic [6:0] cb;
   assign cmd = take && atn;
   assign cb  = rx_byte_ff[6:0];

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i || ifc)
      begin
         listen_ff <= 1'b0;
         talk_ff   <= 1'b0;
         spe_ff    <= 1'b0;
      end
      else if (cmd)
      begin
         if ({1'b0, cb} == CMD_UNL)
            listen_ff <= 1'b0;
         else if (is_addr({1'b0, cb}, GRP_LAD))
         begin
            listen_ff <= 1'b1;
            talk_ff   <= 1'b0;
         end
         if ({1'b0, cb} == CMD_UNT)
            talk_ff <= 1'b0;
         else if (is_addr({1'b0, cb}, GRP_TAD))
         begin
            talk_ff   <= 1'b1;
            listen_ff <= 1'b0;
         end
         if ({1'b0, cb} == CMD_SPE)
            spe_ff <= 1'b1;
         else if ({1'b0, cb} == CMD_SPD)
            spe_ff <= 1'b0;
      end
   end

   // remote / local with lockout
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i || !ren)
      begin
         remote_ff  <= 1'b0;
         lockout_ff <= 1'b0;
      end
      else if (cmd)
      begin
         if ({1'b0, cb} == CMD_LLO)
            lockout_ff <= 1'b1;
         if (is_addr({1'b0, cb}, GRP_LAD))
            remote_ff <= 1'b1;
         else if ({1'b0, cb} == CMD_GTL && listen_ff)
            remote_ff <= 1'b0;
      end
   end

   // parallel poll configuration
   logic ppc_pend_ff;
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i || ifc)
      begin
         ppe_ff      <= 1'b0;
         ppsense_ff  <= 1'b0;
         ppline_ff   <= 3'h0;
         ppc_pend_ff <= 1'b0;
      end
      else if (cmd)
      begin
         if ({1'b0, cb} == CMD_PPU)
            ppe_ff <= 1'b0;
         if ({1'b0, cb} == CMD_PPC && listen_ff)
            ppc_pend_ff <= 1'b1;
         else if (ppc_pend_ff && cb[6:4] == GRP_PPE[2:0])
         begin
            ppe_ff      <= 1'b1;
            ppsense_ff  <= cb[3];
            ppline_ff   <= cb[2:0];
            ppc_pend_ff <= 1'b0;
         end
         else if (ppc_pend_ff && cb[6:4] == GRP_PPD[2:0])
         begin
            ppe_ff      <= 1'b0;
            ppc_pend_ff <= 1'b0;
         end
         else if (cb[6:5] != 2'h0)
            ppc_pend_ff <= 1'b0;
      end
   end

   // device clear and trigger pulses
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         clr_ff  <= 1'b0;
         trig_ff <= 1'b0;
      end
      else
      begin
         clr_ff  <= cmd && ({1'b0, cb} == CMD_DCL ||
                    ({1'b0, cb} == CMD_SDC && listen_ff));
         trig_ff <= cmd && {1'b0, cb} == CMD_GET && listen_ff;
      end
   end

   assign fifo_in_valid = take && !atn && listen_ff;

   gpib_fifo #(.WIDTH(9), .DEPTH(GPIB_FIFO_DEPTH)) u_fifo
   (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .in_valid_i  (fifo_in_valid),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   ({rx_eoi_ff, rx_byte_ff}),
      .out_valid_o (rx_valid_o),
      .out_ready_i (rx_ready_i),
      .out_data_o  (fifo_out),
      .flush_i     (clr_ff)
   );
   assign rx_data_o = fifo_out[7:0];
   assign rx_end_o  = fifo_out[8];

   // source handshake
   gpib_sh_e   sh_ff;
   logic [7:0] tx_byte_ff;
   logic       tx_eoi_ff;
   logic [2:0] settle_ff;
   logic       src_active;
   assign src_active = talk_ff && !atn;
   assign tx_ready_o = (sh_ff == GPIB_SH_IDLE) && src_active && !spe_ff;

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i || ifc || !src_active)
      begin
         sh_ff      <= GPIB_SH_IDLE;
         tx_byte_ff <= 8'h00;
         tx_eoi_ff  <= 1'b0;
         settle_ff  <= 3'h0;
      end
      else
      begin
         unique case (sh_ff)
            GPIB_SH_IDLE:
               if (spe_ff)
               begin
                  tx_byte_ff <= {rsv_i, status_i};
                  tx_eoi_ff  <= 1'b0;
                  sh_ff      <= GPIB_SH_WRDY;
               end
               else if (tx_valid_i)
               begin
                  tx_byte_ff <= tx_data_i;
                  tx_eoi_ff  <= tx_end_i;
                  sh_ff      <= GPIB_SH_WRDY;
               end
            GPIB_SH_WRDY:
               if (!nrfd)
               begin
                  settle_ff <= SETTLE_CNT;
                  sh_ff     <= GPIB_SH_SETL;
               end
            GPIB_SH_SETL:
               if (settle_ff == 3'h0)
                  sh_ff <= GPIB_SH_WACC;
               else
                  settle_ff <= settle_ff - 3'h1;
            GPIB_SH_WACC:
               if (!ndac)
                  sh_ff <= GPIB_SH_IDLE;
         endcase
      end
   end

   // parallel poll response
   logic pp_resp;
   assign pp_resp = atn && eoi && ppe_ff && (ist_i == ppsense_ff);
   logic [7:0] pp_bits;
   always_comb
   begin
      pp_bits = 8'h00;
      pp_bits[ppline_ff] = 1'b1;
   end

   // bus drivers
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         dio_n_o   <= 8'hff;
         dio_oe_o  <= 1'b0;
         eoi_n_o   <= 1'b1;
         eoi_oe_o  <= 1'b0;
         dav_n_o   <= 1'b1;
         dav_oe_o  <= 1'b0;
         nrfd_n_o  <= 1'b1;
         nrfd_oe_o <= 1'b0;
         ndac_n_o  <= 1'b1;
         ndac_oe_o <= 1'b0;
         srq_n_o   <= 1'b1;
         srq_oe_o  <= 1'b0;
      end
      else
      begin
         if (pp_resp)
         begin
            dio_n_o  <= ~pp_bits;
            dio_oe_o <= 1'b1;
         end
         else
         begin
            dio_n_o  <= ~tx_byte_ff;
            dio_oe_o <= sh_ff != GPIB_SH_IDLE && src_active;
         end
         eoi_n_o   <= ~(tx_eoi_ff && sh_ff != GPIB_SH_IDLE);
         eoi_oe_o  <= src_active && sh_ff != GPIB_SH_IDLE;
         dav_n_o   <= ~(sh_ff == GPIB_SH_WACC && src_active);
         dav_oe_o  <= src_active && !ifc;
         nrfd_n_o  <= ~nrfd_hold;
         nrfd_oe_o <= nrfd_hold;
         ndac_n_o  <= ~ndac_hold;
         ndac_oe_o <= ndac_hold;
         srq_n_o   <= ~(rsv_i && !(spe_ff && talk_ff));
         srq_oe_o  <= rsv_i && !(spe_ff && talk_ff);
      end
   end

   assign remote_o    = remote_ff;
   assign lockout_o   = lockout_ff;
   assign listen_o    = listen_ff;
   assign talk_o      = talk_ff;
   assign trigger_o   = trig_ff;
   assign dev_clear_o = clr_ff;

   // assertions
   no_dav_unready_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      sh_ff == GPIB_SH_SETL && $past(sh_ff) == GPIB_SH_WRDY |-> $past(!nrfd))
      else $error("data valid without ready");
   dav_data_stable_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !dav_n_o && $past(!dav_n_o) |-> $stable(dio_n_o) || pp_resp)
      else $error("data moved under data valid");
   ndac_until_take_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      take |-> !ndac_n_o || !ndac_oe_o)
      else $error("ndac released early");
   remote_needs_ren_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      remote_ff |-> $past(ren))
      else $error("remote without enable");
   ifc_clears_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ifc |=> !listen_ff && !talk_ff)
      else $error("interface clear ignored");
   mta_unlisten_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      cmd && is_addr({1'b0, cb}, GRP_TAD) && !ifc |=> !listen_ff)
      else $error("listener kept after own talk address");
   mla_untalk_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      cmd && is_addr({1'b0, cb}, GRP_LAD) && !ifc |=> !talk_ff)
      else $error("talker kept after own listen address");
   get_trigger_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      cmd && {1'b0, cb} == CMD_GET && listen_ff |=> trigger_o)
      else $error("trigger missed");
   srq_drive_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rsv_i && !spe_ff ##1 rsv_i |-> !srq_n_o)
      else $error("service request not driven");
   rx_cover_c: cover property (@(posedge clk_i) fifo_in_valid && rx_eoi_ff);
   tx_cover_c: cover property (@(posedge clk_i) sh_ff == GPIB_SH_WACC ##1 sh_ff == GPIB_SH_IDLE);
   pp_cover_c: cover property (@(posedge clk_i) pp_resp);
endmodule
`default_nettype wire

/* rtl/gpib_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module gpib_fifo
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
)
(
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   // fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o,
   // flush
   input  wire logic             flush_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ff;
   logic [AW:0]      rd_ff;
   logic             push;
   logic             pop;

   assign in_ready_o  = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_ff != rd_ff;
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem[rd_ff[AW-1:0]];

   always_ff @(posedge clk_i)
   begin
      if (push)
         mem[wr_ff[AW-1:0]] <= in_data_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i || flush_i)
      begin
         wr_ff <= '0;
         rd_ff <= '0;
      end
      else
      begin
         wr_ff <= wr_ff + (AW+1)'(push);
         rd_ff <= rd_ff + (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

/* test/gpib_ctl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module gpib_ctl_model
(
   // clock
   input  wire logic       clk_i,
   // resolved bus lines
   input  wire logic [7:0] dio_n_i,
   input  wire logic       dav_n_i,
   input  wire logic       nrfd_n_i,
   input  wire logic       ndac_n_i,
   input  wire logic       eoi_n_i,
   // controller drive, high when released
   output logic      [7:0] dio_n_o,
   output logic            atn_n_o,
   output logic            eoi_n_o,
   output logic            dav_n_o,
   output logic            nrfd_n_o,
   output logic            ndac_n_o
);
   int         err_cnt = 0;
   int         slow    = 0;
   logic       dav_q   = 1'b1;
   logic [7:0] dio_q   = 8'hff;
   initial
   begin
      dio_n_o  = 8'hff;
      atn_n_o  = 1'b1;
      eoi_n_o  = 1'b1;
      dav_n_o  = 1'b1;
      nrfd_n_o = 1'b1;
      ndac_n_o = 1'b1;
   end
   // byte must not move while data valid is held
   always @(posedge clk_i)
   begin
      if (!dav_n_i && !dav_q && dio_n_i !== dio_q)
      begin
         $display("MISMATCH dio_stable expected %h seen %h", dio_q, dio_n_i);
         err_cnt++;
      end
      dav_q <= dav_n_i;
      dio_q <= dio_n_i;
   end
   function automatic logic line(input int sel);
      logic [2:0] l;
      l = {ndac_n_i, nrfd_n_i, dav_n_i};
      return l[sel];
   endfunction
   task automatic wait_on(input int sel, input logic v);
      int n;
      n = 0;
      while (line(sel) !== v && n < 3000)
      begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 3000)
      begin
         $display("MISMATCH handshake expected %b seen %b", v, line(sel));
         err_cnt++;
      end
   endtask
   task automatic set_atn(input logic a);
      @(posedge clk_i);
      atn_n_o <= ~a;
      repeat (4) @(posedge clk_i);
   endtask
   task automatic send_byte(input logic atn, input logic [7:0] b, input logic eoi);
      @(posedge clk_i);
      nrfd_n_o <= 1'b1;
      ndac_n_o <= 1'b1;
      atn_n_o  <= ~atn;
      eoi_n_o  <= ~eoi;
      dio_n_o  <= ~b;
      @(posedge clk_i);
      wait_on(1, 1'b1);
      repeat (3 + slow) @(posedge clk_i);
      dav_n_o  <= 1'b0;
      @(posedge clk_i);
      wait_on(2, 1'b1);
      dav_n_o  <= 1'b1;
      dio_n_o  <= 8'hff;
      eoi_n_o  <= 1'b1;
   endtask
   task automatic hold();
      @(posedge clk_i);
      nrfd_n_o <= 1'b0;
      ndac_n_o <= 1'b0;
   endtask
   task automatic recv_byte(output logic [7:0] b, output logic e);
      repeat (slow + 1) @(posedge clk_i);
      nrfd_n_o <= 1'b1;
      wait_on(0, 1'b0);
      b = ~dio_n_i;
      e = ~eoi_n_i;
      nrfd_n_o <= 1'b0;
      ndac_n_o <= 1'b1;
      @(posedge clk_i);
      wait_on(0, 1'b1);
      ndac_n_o <= 1'b0;
   endtask
   task automatic par_poll(output logic [7:0] r);
      @(posedge clk_i);
      atn_n_o <= 1'b0;
      eoi_n_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      r = ~dio_n_i;
      eoi_n_o <= 1'b1;
      repeat (4) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

/* test/gpib_instrument_interface_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module gpib_instrument_interface_tb;
   import gpib_pkg::*;
   logic       clk    = 1'b0;
   logic       rst    = 1'b1;
   logic       ifc_n  = 1'b1;
   logic       ren_n  = 1'b1;
   logic [4:0] addr   = 5'h01;
   logic       rx_rdy = 1'b0;
   logic       tx_vld = 1'b0;
   logic [7:0] tx_dat = 8'h00;
   logic       tx_eoi = 1'b0;
   logic       rsv    = 1'b0;
   logic [6:0] stat   = 7'h00;
   logic       ist    = 1'b0;
   int         error_cnt = 0;
   int         checks    = 0;
   int         trig_n    = 0;
   int         clr_n     = 0;
   wire  [7:0] c_dio, d_dio, dio_w, rx_dat;
   wire        c_atn, c_eoi, c_dav, c_nrfd, c_ndac, d_eoi, d_srq, d_dav, d_nrfd, d_ndac;
   wire        dio_oe, eoi_oe, srq_oe, dav_oe, nrfd_oe, ndac_oe, rx_vld, rx_end, tx_rdy;
   wire        remote, lockout, listen, talk, trig, dclr;
   wire        eoi_w, srq_w, dav_w, nrfd_w, ndac_w;
   assign dio_w  = c_dio & (dio_oe ? d_dio : 8'hff);
   assign eoi_w  = c_eoi & (eoi_oe ? d_eoi : 1'b1);
   assign srq_w  = srq_oe ? d_srq : 1'b1;
   assign dav_w  = c_dav & (dav_oe ? d_dav : 1'b1);
   assign nrfd_w = c_nrfd & (nrfd_oe ? d_nrfd : 1'b1);
   assign ndac_w = c_ndac & (ndac_oe ? d_ndac : 1'b1);
   gpib_dev i_dut (.clk_i(clk), .sys_rst_i(rst), .dio_n_i(dio_w), .dio_n_o(d_dio),
      .dio_oe_o(dio_oe), .atn_n_i(c_atn), .ifc_n_i(ifc_n), .ren_n_i(ren_n), .eoi_n_i(eoi_w),
      .eoi_n_o(d_eoi), .eoi_oe_o(eoi_oe), .srq_n_o(d_srq), .srq_oe_o(srq_oe), .dav_n_i(dav_w),
      .dav_n_o(d_dav), .dav_oe_o(dav_oe), .nrfd_n_i(nrfd_w), .nrfd_n_o(d_nrfd),
      .nrfd_oe_o(nrfd_oe), .ndac_n_i(ndac_w), .ndac_n_o(d_ndac), .ndac_oe_o(ndac_oe),
      .my_addr_i(addr), .lpe_i(1'b0), .rx_valid_o(rx_vld), .rx_ready_i(rx_rdy),
      .rx_data_o(rx_dat), .rx_end_o(rx_end), .tx_valid_i(tx_vld), .tx_ready_o(tx_rdy),
      .tx_data_i(tx_dat), .tx_end_i(tx_eoi), .rsv_i(rsv), .status_i(stat), .ist_i(ist),
      .remote_o(remote), .lockout_o(lockout), .listen_o(listen), .talk_o(talk),
      .trigger_o(trig), .dev_clear_o(dclr));
   gpib_ctl_model i_ctl (.clk_i(clk), .dio_n_i(dio_w), .dav_n_i(dav_w), .nrfd_n_i(nrfd_w),
      .ndac_n_i(ndac_w), .eoi_n_i(eoi_w), .dio_n_o(c_dio), .atn_n_o(c_atn), .eoi_n_o(c_eoi),
      .dav_n_o(c_dav), .nrfd_n_o(c_nrfd), .ndac_n_o(c_ndac));
   initial
   begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (trig === 1'b1)
         trig_n++;
      if (dclr === 1'b1)
         clr_n++;
   end
   function automatic logic [7:0] lad(input logic [4:0] a);
      return {GRP_LAD, a};
   endfunction
   function automatic logic [7:0] tad(input logic [4:0] a);
      return {GRP_TAD, a};
   endfunction
   function automatic logic [7:0] ppe(input logic s, input logic [2:0] l);
      return {GRP_PPE, s, l};
   endfunction
   task automatic finish_test();
      error_cnt += i_ctl.err_cnt;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (e !== g)
      begin
         $display("MISMATCH %s expected %h seen %h", n, e, g);
         error_cnt++;
      end
   endtask
   task automatic cmd(input logic [7:0] b);
      i_ctl.send_byte(1'b1, b, 1'b0);
      repeat (8) @(posedge clk);
   endtask
   task automatic tx(input logic [7:0] d, input logic e);
      @(posedge clk);
      tx_vld <= 1'b1;
      tx_dat <= d;
      tx_eoi <= e;
      @(negedge clk);
      while (tx_rdy !== 1'b1)
         @(negedge clk);
      @(posedge clk);
      tx_vld <= 1'b0;
   endtask
   task automatic pop(output logic [7:0] d, output logic e);
      @(posedge clk);
      rx_rdy <= 1'b1;
      @(negedge clk);
      while (rx_vld !== 1'b1)
         @(negedge clk);
      d = rx_dat;
      e = rx_end;
      @(posedge clk);
      rx_rdy <= 1'b0;
   endtask
   initial
   begin
      #1_000_000;
      $display("MISMATCH watchdog expected done seen timeout");
      error_cnt++;
      finish_test();
   end
   initial
   begin
      logic [7:0] b;
      logic       e;
      logic [8:0] q[$];
      int         ln;
      logic       s;
      void'($urandom(32'h22a9));
      addr <= 5'($urandom % 30 + 1);
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk("reset_oe", 0, {dio_oe, eoi_oe, srq_oe, dav_oe, nrfd_oe, ndac_oe});
      chk("reset_st", 0, {remote, lockout, listen, talk});
      ren_n <= 1'b0;
      cmd(lad(addr));
      chk("listen", 1, listen);
      chk("remote", 1, remote);
      for (int i = 0; i <= GPIB_FIFO_DEPTH; i++)
         q.push_back({1'($urandom % 4 == 0), 8'($urandom)});
      for (int i = 0; i < GPIB_FIFO_DEPTH; i++)
      begin
         i_ctl.slow = $urandom % 5;
         i_ctl.send_byte(1'b0, q[i][7:0], q[i][8]);
      end
      fork
         i_ctl.send_byte(1'b0, q[GPIB_FIFO_DEPTH][7:0], q[GPIB_FIFO_DEPTH][8]);
         begin
            repeat (40) @(posedge clk);
            chk("nrfd_full", 0, nrfd_w);
            foreach (q[i])
            begin
               pop(b, e);
               chk("rx_byte", q[i], {e, b});
            end
         end
      join
      i_ctl.send_byte(1'b0, CMD_GET, 1'b0);
      repeat (8) @(posedge clk);
      chk("data_get", 0, trig_n);
      cmd(CMD_GET);
      chk("trigger", 1, trig_n);
      chk("fifo_hold", 1, rx_vld);
      cmd(CMD_DCL);
      chk("dclr", 1, clr_n);
      chk("flush", 0, rx_vld);
      cmd(CMD_LLO);
      chk("lockout", 1, lockout);
      cmd(CMD_GTL);
      chk("gtl", 0, remote);
      cmd(CMD_PPC);
      ln = $urandom % 8;
      s = 1'($urandom % 2);
      cmd(ppe(s, 3'(ln)));
      for (int k = 0; k < 2; k++)
      begin
         ist <= s ^ k[0];
         repeat (4) @(posedge clk);
         i_ctl.par_poll(b);
         chk("ppoll", k == 0, b[ln]);
      end
      ist <= s;
      cmd(CMD_PPU);
      i_ctl.par_poll(b);
      chk("ppu", 0, b[ln]);
      cmd(tad(addr));
      chk("talk", 1, talk);
      chk("unlisten", 0, listen);
      i_ctl.set_atn(1'b0);
      i_ctl.hold();
      q.delete();
      for (int i = 0; i < 6; i++)
         q.push_back({i == 5, 8'($urandom)});
      fork
         foreach (q[i]) tx(q[i][7:0], q[i][8]);
         foreach (q[i])
         begin
            i_ctl.slow = $urandom % 6;
            i_ctl.recv_byte(b, e);
            chk("tx_byte", q[i], {e, b});
         end
      join
      rsv <= 1'b1;
      stat <= 7'($urandom);
      repeat (6) @(posedge clk);
      chk("srq", 0, srq_w);
      cmd(CMD_SPE);
      cmd(tad(addr));
      i_ctl.set_atn(1'b0);
      i_ctl.hold();
      i_ctl.recv_byte(b, e);
      chk("spoll", {rsv, stat}, b);
      chk("srq_rel", 1, srq_w);
      cmd(CMD_SPD);
      rsv <= 1'b0;
      cmd(lad(addr));
      chk("untalk", 0, talk);
      cmd(CMD_SDC);
      chk("sdc", 2, clr_n);
      cmd(CMD_UNL);
      chk("unl", 0, listen);
      cmd(lad(addr));
      chk("relisten", 1, listen);
      ren_n <= 1'b1;
      repeat (8) @(posedge clk);
      chk("ren_off", 0, {remote, lockout});
      ifc_n <= 1'b0;
      repeat (8) @(posedge clk);
      ifc_n <= 1'b1;
      repeat (8) @(posedge clk);
      chk("ifc", 0, {listen, talk});
      finish_test();
   end
endmodule
`default_nettype wire
